/* File: logic/ddr2_timing_defines.svh */
/*
 file holds the timing constants of the memory-side command timing logic
 and the plain-words list of its behaviour.
 assumes a single 50 MHz core clock (20 ns period) drives every counter.
*/
// Function
// - memory delays internal precharge until row active minimum is met
// - read data starts exactly the programmed read latency after the read, for read latencies of 2 or more
// - memory accepts refresh bursts back to back, no maximum spacing
// - termination turn-off begins 3 clocks (2.5 rounded up) after control sampled inactive
`ifndef DDR2_TIMING_DEFINES_SVH
`define DDR2_TIMING_DEFINES_SVH

`define CLK_PERIOD_PS          20000
`define ROW_ACTIVE_MIN_PS      40000
`define BANK_PRECHARGE_PS      15000
`define ROW_ACTIVE_MIN_CYC     ((`ROW_ACTIVE_MIN_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define BANK_PRECHARGE_CYC     ((`BANK_PRECHARGE_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define TERM_OFF_HALF_CYC      5
`define CKE_MIN_EDGES          3
`define NUM_BANKS              4
`define CNT_W                  8
`define LAT_W                  4

`endif

/* File: logic/ddr2_timing_pkg.sv */
/*
 package holds the shared types of the command timing logic.
 assumes the defines header supplies widths.
*/
`include "ddr2_timing_defines.svh"
package ddr2_timing_pkg;
  typedef enum logic [2:0] {
    CMD_NOP, CMD_ACT, CMD_RD, CMD_WR, CMD_PRE, CMD_PREALL, CMD_REF
  } cmd_t;
  typedef enum logic [1:0] { BANK_IDLE, BANK_OPEN, BANK_AP_WAIT } bank_state_t;
endpackage : ddr2_timing_pkg

/* File: logic/bank_tracker.sv */
/*
 one bank: row-active lockout and held-back auto precharge.
 assumes commands arrive already decoded on the core clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ddr2_timing_defines.svh"
module bank_tracker (
  input  wire logic                core_clk,
  input  wire logic                resetn,
  input  wire logic                act,
  input  wire logic                ap_req,
  input  wire logic                pre,
  output logic                     open_r,
  output logic                     ap_fire_r
);
  ddr2_timing_pkg::bank_state_t state_r;
  ddr2_timing_pkg::bank_state_t state_nxt;
  logic [`CNT_W-1:0]               ras_cnt_r;
  wire                             ras_done = (ras_cnt_r == 8'h00);
  // independent age count, so the lockout check does not trust ras_cnt_r
  logic [`CNT_W-1:0]               act_age_r;

  // auto precharge may be requested early; it waits here for row active
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ddr2_timing_pkg::BANK_IDLE:    if (act) state_nxt = ddr2_timing_pkg::BANK_OPEN;
      ddr2_timing_pkg::BANK_OPEN: begin
        if (pre) state_nxt = ddr2_timing_pkg::BANK_IDLE;
        else if (ap_req) state_nxt = ddr2_timing_pkg::BANK_AP_WAIT;
      end
      ddr2_timing_pkg::BANK_AP_WAIT: if (ras_done) state_nxt = ddr2_timing_pkg::BANK_IDLE;
      default: state_nxt = ddr2_timing_pkg::BANK_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state_r   <= ddr2_timing_pkg::BANK_IDLE;
      ras_cnt_r <= 8'h00;
      act_age_r <= 8'h00;
      open_r    <= 1'b0;
      ap_fire_r <= 1'b0;
    end else begin
      state_r   <= state_nxt;
      if (act && state_r == ddr2_timing_pkg::BANK_IDLE)
        ras_cnt_r <= `CNT_W'(`ROW_ACTIVE_MIN_CYC - 1);
      else if (!ras_done)
        ras_cnt_r <= ras_cnt_r - 8'h01;
      if (act && state_r == ddr2_timing_pkg::BANK_IDLE)
        act_age_r <= 8'h00;
      else if (act_age_r != 8'hff)
        act_age_r <= act_age_r + 8'h01;
      open_r    <= (state_nxt != ddr2_timing_pkg::BANK_IDLE);
      ap_fire_r <= (state_r == ddr2_timing_pkg::BANK_AP_WAIT) && ras_done;
    end
  end

  a_ap_after_ras: assert property (@(posedge core_clk) disable iff (!resetn)
    (state_r == ddr2_timing_pkg::BANK_AP_WAIT && !ras_done) |=> !ap_fire_r)
    else $error("auto precharge fired before row active minimum");
  a_ap_row_age: assert property (@(posedge core_clk) disable iff (!resetn)
    ap_fire_r |-> (act_age_r >= `CNT_W'(`ROW_ACTIVE_MIN_CYC)))
    else $error("auto precharge earlier than row active minimum after activate");
  a_ap_single: assert property (@(posedge core_clk) disable iff (!resetn)
    ap_fire_r |=> !ap_fire_r)
    else $error("internal precharge pulse longer than one cycle");
  c_ap_wait: cover property (@(posedge core_clk) disable iff (!resetn)
    state_r == ddr2_timing_pkg::BANK_AP_WAIT ##1 ap_fire_r);
endmodule : bank_tracker
`default_nettype wire

/* File: logic/ddr2_cmd_timing.sv */
/*
 memory-side command timing: bank lockout, read latency pipe, clock-enable
 registration, termination turn-off delay, refresh acceptance.
 assumes command pins are already synchronised by the caller.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ddr2_timing_defines.svh"
module ddr2_cmd_timing (
  input  wire logic                       core_clk,
  input  wire logic                       resetn,
  input  wire logic [2:0]                 cmd_pin,
  input  wire logic [1:0]                 bank_pin,
  input  wire logic                       autoprecharge_pin,
  input  wire logic [`LAT_W-1:0]          cas_latency,
  input  wire logic [`LAT_W-1:0]          additive_latency,
  input  wire logic                       clock_enable_pin,
  input  wire logic                       die_termination_control,
  output logic [`NUM_BANKS-1:0]           bank_open_r,
  output logic [`NUM_BANKS-1:0]           internal_precharge_r,
  output logic                            read_data_start_r,
  output logic                            clock_enable_reg_r,
  output logic                            termination_on_r,
  output logic                            refresh_accept_r
);
  logic [2:0]   cmd_s1_r, cmd_s2_r;
  logic [1:0]   bank_s1_r, bank_s2_r;
  logic         ap_s1_r, ap_s2_r, cke_s1_r, cke_s2_r, odt_s1_r, odt_s2_r;
  logic [31:0]  rd_pipe_r;
  logic [3:0]   term_cnt_r;
  logic         cke_prev_r;
  logic [1:0]   cke_edges_r;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      cmd_s1_r <= 3'h0;
      cmd_s2_r <= 3'h0;
      bank_s1_r <= 2'h0;
      bank_s2_r <= 2'h0;
      ap_s1_r <= 1'b0;
      ap_s2_r <= 1'b0;
      cke_s1_r <= 1'b0;
      cke_s2_r <= 1'b0;
      odt_s1_r <= 1'b0;
      odt_s2_r <= 1'b0;
    end else begin
      cmd_s1_r <= cmd_pin;
      cmd_s2_r <= cmd_s1_r;
      bank_s1_r <= bank_pin;
      bank_s2_r <= bank_s1_r;
      ap_s1_r <= autoprecharge_pin;
      ap_s2_r <= ap_s1_r;
      cke_s1_r <= clock_enable_pin;
      cke_s2_r <= cke_s1_r;
      odt_s1_r <= die_termination_control;
      odt_s2_r <= odt_s1_r;
    end
  end

  // one decode for all commands; clock enable low turns every code to nop
  function automatic logic cmd_is(input logic [2:0] code,
                                  input ddr2_timing_pkg::cmd_t kind);
    return code == 3'(kind);
  endfunction : cmd_is

  wire cmd_act  = cmd_is(cmd_s2_r, ddr2_timing_pkg::CMD_ACT) && cke_s2_r;
  wire cmd_rd   = cmd_is(cmd_s2_r, ddr2_timing_pkg::CMD_RD) && cke_s2_r;
  wire cmd_wr   = cmd_is(cmd_s2_r, ddr2_timing_pkg::CMD_WR) && cke_s2_r;
  wire cmd_pre  = cmd_is(cmd_s2_r, ddr2_timing_pkg::CMD_PRE) && cke_s2_r;
  wire cmd_pall = cmd_is(cmd_s2_r, ddr2_timing_pkg::CMD_PREALL) && cke_s2_r;
  wire cmd_ref  = cmd_is(cmd_s2_r, ddr2_timing_pkg::CMD_REF) && cke_s2_r;
  wire [4:0] read_latency = 5'(cas_latency) + 5'(additive_latency);

  genvar b;
  generate
    for (b = 0; b < `NUM_BANKS; b++) begin : g_bank
      wire sel = (bank_s2_r == 2'(b));
      bank_tracker u_bank (
        .core_clk  (core_clk),
        .resetn    (resetn),
        .act       (cmd_act && sel),
        .ap_req    ((cmd_rd || cmd_wr) && ap_s2_r && sel),
        .pre       ((cmd_pre && sel) || cmd_pall),
        .open_r    (bank_open_r[b]),
        .ap_fire_r (internal_precharge_r[b])
      );
    end
  endgenerate

  // read pipe: bit k loaded at the read means first data leaves k+2 clocks after the read
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rd_pipe_r <= 32'h0;
      read_data_start_r <= 1'b0;
    end else begin
      rd_pipe_r <= (rd_pipe_r >> 1) |
                   (cmd_rd ? (32'h1 << (read_latency - 5'h2)) : 32'h0);
      read_data_start_r <= rd_pipe_r[0];
    end
  end

  // level counts as registered after three sampled edges
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      cke_prev_r <= 1'b0;
      cke_edges_r <= 2'h0;
      clock_enable_reg_r <= 1'b0;
    end else begin
      cke_prev_r <= cke_s2_r;
      if (cke_s2_r != cke_prev_r)
        cke_edges_r <= 2'h1;
      else if (cke_edges_r != 2'(`CKE_MIN_EDGES))
        cke_edges_r <= cke_edges_r + 2'h1;
      if (cke_edges_r == 2'(`CKE_MIN_EDGES - 1) && cke_s2_r == cke_prev_r)
        clock_enable_reg_r <= cke_s2_r;
    end
  end

  // half clocks cannot be made on one edge; rounded up to three clocks
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      term_cnt_r <= 4'h0;
      termination_on_r <= 1'b0;
      refresh_accept_r <= 1'b0;
    end else begin
      refresh_accept_r <= cmd_ref;
      if (odt_s2_r) begin
        term_cnt_r <= 4'h0;
        termination_on_r <= 1'b1;
      end else if (termination_on_r) begin
        term_cnt_r <= term_cnt_r + 4'h1;
        if (term_cnt_r == 4'((`TERM_OFF_HALF_CYC + 1) / 2 - 1))
          termination_on_r <= 1'b0;
      end
    end
  end

  a_read_latency: assert property (@(posedge core_clk) disable iff (!resetn)
    (cmd_rd && read_latency == 5'h5) |-> ##5 read_data_start_r)
    else $error("read data start not at programmed latency");
  a_term_off: assert property (@(posedge core_clk) disable iff (!resetn)
    ($fell(odt_s2_r) && termination_on_r) |-> termination_on_r ##[1:3] !termination_on_r)
    else $error("termination turn-off delay wrong");
  a_refresh_burst: assert property (@(posedge core_clk) disable iff (!resetn)
    cmd_ref |=> refresh_accept_r)
    else $error("refresh in burst not accepted");
  a_cke_hold: assert property (@(posedge core_clk) disable iff (!resetn)
    $changed(clock_enable_reg_r) |-> $past(cke_s2_r, 1) == clock_enable_reg_r)
    else $error("clock enable registered wrong level");
  a_cke_gates_ref: assert property (@(posedge core_clk) disable iff (!resetn)
    !cke_s2_r |=> !refresh_accept_r)
    else $error("refresh taken while clock enable low");
  a_term_on: assert property (@(posedge core_clk) disable iff (!resetn)
    odt_s2_r |=> termination_on_r)
    else $error("termination not on while requested");
  c_read: cover property (@(posedge core_clk) disable iff (!resetn) read_data_start_r);
  c_ref2: cover property (@(posedge core_clk) disable iff (!resetn) cmd_ref ##1 cmd_ref);
  c_term: cover property (@(posedge core_clk) disable iff (!resetn) $fell(termination_on_r));
endmodule : ddr2_cmd_timing
`default_nettype wire

/* File: bench/mem_ctrl_model.sv */
/*
 controller stand-in: registers requested commands onto the pins.
 assumes requests change just after a rising edge.
*/
`timescale 1ns/1ps
`default_nettype none
module mem_ctrl_model (
  input  wire logic       core_clk,
  input  wire logic       resetn,
  input  wire logic [2:0] req_cmd,
  input  wire logic [1:0] req_bank,
  input  wire logic       req_ap,
  input  wire logic       req_cke,
  output logic      [2:0] cmd_pin,
  output logic      [1:0] bank_pin,
  output logic            autoprecharge_pin,
  output logic            clock_enable_pin
);
  // commands pass as requested, back to back included; only clock enable changes are spaced apart
  logic [1:0] hold_r;
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      cmd_pin <= 3'h0;
      bank_pin <= 2'h0;
      autoprecharge_pin <= 1'b0;
      clock_enable_pin <= 1'b0;
      hold_r <= 2'h0;
    end else begin
      cmd_pin <= req_cmd;
      // unselected bank lines toggle so stale values cannot pass
      bank_pin <= (req_cmd == 3'h0) ? ~bank_pin : req_bank;
      autoprecharge_pin <= req_ap;
      if (hold_r != 2'h0)
        hold_r <= hold_r - 2'h1;
      else if (req_cke != clock_enable_pin) begin
        clock_enable_pin <= req_cke;
        hold_r <= 2'h2;
      end
    end
  end
endmodule : mem_ctrl_model
`default_nettype wire

/* File: bench/ddr2_cmd_timing_tb.sv */
/*
 bench for the memory-side command timing block.
 assumes the controller stand-in drives the command pins.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ddr2_timing_defines.svh"
module ddr2_cmd_timing_tb;
  logic [2:0] req_cmd = 3'h0;
  logic [1:0] req_bank = 2'h0;
  logic core_clk = 1'b0, resetn = 1'b0, req_ap = 1'b0, req_cke = 1'b0;
  logic [`LAT_W-1:0] cas_latency = 4'h3, additive_latency = 4'h0;
  logic die_termination_control = 1'b0;
  wire logic [2:0] cmd_pin;
  wire logic [1:0] bank_pin;
  wire logic autoprecharge_pin, clock_enable_pin;
  wire logic [`NUM_BANKS-1:0] bank_open_r, internal_precharge_r;
  wire logic read_data_start_r, clock_enable_reg_r;
  wire logic termination_on_r, refresh_accept_r;
  int err_total = 0;
  int num_checks = 0;
  always #10 core_clk = ~core_clk;
  mem_ctrl_model u_ctrl (.core_clk, .resetn, .req_cmd, .req_bank,
    .req_ap, .req_cke, .cmd_pin, .bank_pin, .autoprecharge_pin,
    .clock_enable_pin);
  ddr2_cmd_timing u_dut (.core_clk, .resetn, .cmd_pin, .bank_pin,
    .autoprecharge_pin, .cas_latency, .additive_latency,
    .clock_enable_pin, .die_termination_control, .bank_open_r,
    .internal_precharge_r, .read_data_start_r, .clock_enable_reg_r,
    .termination_on_r, .refresh_accept_r);
  task automatic check(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %s expected %0h seen %0h", what, exp, got);
    end
  endtask : check
  task automatic report_and_stop;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop
  function automatic logic pick(input int w);
    case (w)
      0: pick = refresh_accept_r;
      1: pick = read_data_start_r;
      2: pick = |internal_precharge_r;
      3: pick = termination_on_r;
      default: pick = clock_enable_reg_r;
    endcase
  endfunction : pick
  // counts edges from the sampling edge; a hang ends the run
  task automatic wait_for(input int w, input logic lvl, output int n);
    n = 0;
    do begin
      @(posedge core_clk);
      #1;
      n++;
      if (n > 40) begin
        check("wait bound", 8'h0, 8'h1);
        report_and_stop();
      end
    end while (pick(w) !== lvl);
  endtask : wait_for
  task automatic send(input logic [2:0] c, input logic [1:0] b,
                      input logic ap, input int k);
    @(posedge core_clk);
    req_cmd <= c;
    req_bank <= b;
    req_ap <= ap;
    repeat (k) @(posedge core_clk);
    req_cmd <= 3'h0;
    req_ap <= 1'b0;
  endtask : send
  task automatic count_refresh(input logic [7:0] exp);
    int seen;
    seen = 0;
    repeat (8) begin
      @(posedge core_clk);
      #1;
      seen += (refresh_accept_r === 1'b1);
    end
    check("refresh accepts", exp, 8'(seen));
  endtask : count_refresh
  task automatic refresh_burst;
    send(3'h6, 2'h0, 1'b0, 3);
    count_refresh(8'h3);
  endtask : refresh_burst
  task automatic read_case(input logic [3:0] cl, input logic [3:0] al);
    int n;
    @(posedge core_clk);
    cas_latency <= cl;
    additive_latency <= al;
    send(3'h1, 2'h0, 1'b0, 1);
    send(3'h2, 2'h0, 1'b0, 1);
    wait_for(1, 1'b1, n);
    check("read start", 8'(2 + cl + al), 8'(n));
  endtask : read_case
  task automatic row_lockout;
    int n;
    // back to back so the auto precharge lands inside row active time
    @(posedge core_clk);
    req_cmd <= 3'h1;
    req_bank <= 2'h2;
    @(posedge core_clk);
    req_cmd <= 3'h2;
    req_ap <= 1'b1;
    @(posedge core_clk);
    req_cmd <= 3'h0;
    req_ap <= 1'b0;
    wait_for(2, 1'b1, n);
    check("ap held", 8'(2 + `ROW_ACTIVE_MIN_CYC), 8'(n));
    check("ap bank", 8'h4, 8'(internal_precharge_r));
    repeat (2) @(posedge core_clk);
    check("bank closed", 8'h0, 8'(bank_open_r[2]));
  endtask : row_lockout
  task automatic cke_drop;
    int n;
    @(posedge core_clk);
    req_cke <= 1'b0;
    wait_for(4, 1'b0, n);
    check("cke edges", 8'(3 + `CKE_MIN_EDGES), 8'(n));
    send(3'h6, 2'h0, 1'b0, 1);
    count_refresh(8'h0);
    @(posedge core_clk);
    req_cke <= 1'b1;
    wait_for(4, 1'b1, n);
  endtask : cke_drop
  task automatic termination_off;
    int n;
    @(posedge core_clk);
    die_termination_control <= 1'b1;
    wait_for(3, 1'b1, n);
    @(posedge core_clk);
    die_termination_control <= 1'b0;
    wait_for(3, 1'b0, n);
    check("term off delay", 8'(2 + (`TERM_OFF_HALF_CYC + 1) / 2), 8'(n));
  endtask : termination_off
  initial begin
    repeat (10) @(posedge core_clk);
    resetn <= 1'b1;
    req_cke <= 1'b1;
    repeat (8) @(posedge core_clk);
    refresh_burst();
    read_case(4'h3, 4'h0);
    read_case(4'h4, 4'h2);
    row_lockout();
    cke_drop();
    termination_off();
    report_and_stop();
  end
endmodule : ddr2_cmd_timing_tb
`default_nettype wire
